// ==== rtl/csc_regs.sv ====
`timescale 1ns/1ps
`include "csc_defines.svh"
module csc_regs
    import csc_pkg::*;
#(
    parameter logic [31:0] WDOG_CYCLES = `CSC_WDOG_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire csc_mon_type mon,
    output csc_ctl_type ctl,
    output csc_drv_type drv,
    output logic stat_out,
    output logic stat_oe,
    output logic int_out,
    output logic int_oe
);

    localparam logic [11:0] PULSE_CYC = 12'(`CSC_PULSE_NS / `CSC_CLK_NS);
    localparam logic [7:0] CTRL_RST = `CSC_CTRL_RESET;
    localparam csc_ctl_type CTL_DEF = csc_ctl_type'({2'h0, CTRL_RST[`CSC_B_CAP_HI:`CSC_B_HIZ]});

    csc_state_type st_q;
    logic scl_q, sda_q;
    logic [3:0] cnt_q;
    logic [7:0] shift_q, tx_q, ptr_q;
    logic rw_q, mack_q, wr_stb_q, wdog_run_q, wdog_exp_q, prev_valid_q;
    logic [7:0] r0, r1, r2, rd_cur, rd_nxt;
    csc_ctl_type ctl_q;
    csc_drv_type drv_q;
    logic [31:0] wdog_cnt_q;
    logic [11:0] pulse_cnt_q;
    logic [9:0] prev_q;
    logic stat_oe_q, sda_oe_q, zero_q;
    logic start, stop, scl_rise, scl_fall, kick, srst, expire, chg;
    logic [2:0] err_code;

    function automatic logic [7:0] rd_byte(input logic [7:0] a, input logic [7:0] s0,
                                           input logic [7:0] s1, input logic [7:0] s2);
        return a == `CSC_OFS_STATUS ? s0 : a == `CSC_OFS_SUPPLY ? s1 :
               a == `CSC_OFS_CTRL ? s2 : `CSC_UNMAPPED;
    endfunction

    // Kick bit reads zero; the reset bit reads one
    assign err_code = wdog_exp_q ? `CSC_ERR_WDOG : mon.fault_code;
    assign r0 = {1'b0, mon.charge_state, 1'b0, err_code};
    assign r1 = {2'b00, mon.input_supply_state, ctl_q.input_lockout,
                 mon.cell_state, ctl_q.cell_absent_run};
    assign r2 = {1'b1, ctl_q.input_current_cap, ctl_q.stat_en, ctl_q.end_cutoff_on,
                 ctl_q.charge_inhibit, ctl_q.hi_z_state};
    assign rd_cur = rd_byte(ptr_q, r0, r1, r2);
    assign rd_nxt = rd_byte(ptr_q + 8'h01, r0, r1, r2);

    assign start = scl_q && scl_in && sda_q && !sda_in;
    assign stop = scl_q && scl_in && !sda_q && sda_in;
    assign scl_rise = !scl_q && scl_in;
    assign scl_fall = scl_q && !scl_in;
    assign kick = wr_stb_q && ptr_q == `CSC_OFS_STATUS && shift_q[`CSC_B_KICK];
    assign srst = wr_stb_q && ptr_q == `CSC_OFS_CTRL && shift_q[`CSC_B_SRST];
    assign expire = wdog_run_q && wdog_cnt_q == WDOG_CYCLES - 32'h1;
    assign chg = prev_valid_q && prev_q != {r0[6:4], r0[2:0], r1[5:4], r1[2:1]};

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    // Serial slave; a stop or new start always resynchronises the engine
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q <= CSC_IDLE;
            cnt_q <= 4'h0;
            shift_q <= 8'h00;
            tx_q <= 8'h00;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            mack_q <= 1'b0;
            wr_stb_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else begin
            wr_stb_q <= 1'b0;
            if (start) begin
                st_q <= CSC_ADDR;
                cnt_q <= 4'h0;
                sda_oe_q <= 1'b0;
            end else if (stop) begin
                st_q <= CSC_IDLE;
                sda_oe_q <= 1'b0;
            end else if (scl_rise) begin
                if (st_q == CSC_ADDR || st_q == CSC_REG || st_q == CSC_WDATA) begin
                    shift_q <= {shift_q[6:0], sda_in};
                    cnt_q <= cnt_q + 4'h1;
                end else if (st_q == CSC_RDATA) begin
                    cnt_q <= cnt_q + 4'h1;
                end else if (st_q == CSC_RDATA_ACK) begin
                    mack_q <= !sda_in;
                end
            end else if (scl_fall) begin
                unique case (st_q)
                    CSC_IDLE: begin
                        sda_oe_q <= 1'b0;
                    end
                    CSC_ADDR: begin
                        if (cnt_q == 4'h8) begin
                            if (shift_q[7:1] == `CSC_DEV_ADDR) begin
                                st_q <= CSC_ADDR_ACK;
                                sda_oe_q <= 1'b1;
                                rw_q <= shift_q[0];
                            end else begin
                                st_q <= CSC_IDLE;
                            end
                        end
                    end
                    CSC_ADDR_ACK: begin
                        cnt_q <= 4'h0;
                        if (rw_q) begin
                            st_q <= CSC_RDATA;
                            tx_q <= rd_cur;
                            sda_oe_q <= !rd_cur[7];
                        end else begin
                            st_q <= CSC_REG;
                            sda_oe_q <= 1'b0;
                        end
                    end
                    CSC_REG: begin
                        if (cnt_q == 4'h8) begin
                            ptr_q <= shift_q;
                            st_q <= CSC_REG_ACK;
                            sda_oe_q <= 1'b1;
                        end
                    end
                    CSC_REG_ACK: begin
                        st_q <= CSC_WDATA;
                        cnt_q <= 4'h0;
                        sda_oe_q <= 1'b0;
                    end
                    CSC_WDATA: begin
                        if (cnt_q == 4'h8) begin
                            wr_stb_q <= 1'b1;
                            st_q <= CSC_WDATA_ACK;
                            sda_oe_q <= 1'b1;
                        end
                    end
                    CSC_WDATA_ACK: begin
                        ptr_q <= ptr_q + 8'h01;
                        st_q <= CSC_WDATA;
                        cnt_q <= 4'h0;
                        sda_oe_q <= 1'b0;
                    end
                    CSC_RDATA: begin
                        if (cnt_q == 4'h8) begin
                            st_q <= CSC_RDATA_ACK;
                            sda_oe_q <= 1'b0;
                        end else begin
                            tx_q <= {tx_q[6:0], 1'b0};
                            sda_oe_q <= !tx_q[6];
                        end
                    end
                    CSC_RDATA_ACK: begin
                        cnt_q <= 4'h0;
                        if (mack_q) begin
                            ptr_q <= ptr_q + 8'h01;
                            st_q <= CSC_RDATA;
                            tx_q <= rd_nxt;
                            sda_oe_q <= !rd_nxt[7];
                        end else begin
                            st_q <= CSC_IDLE;
                            sda_oe_q <= 1'b0;
                        end
                    end
                endcase
            end
        end
    end

    // Control fields; the soft reset write itself carries no other field
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctl_q <= CTL_DEF;
        end else if (srst) begin
            ctl_q <= CTL_DEF;
        end else begin
            if (wr_stb_q && ptr_q == `CSC_OFS_SUPPLY) begin
                ctl_q.input_lockout <= shift_q[`CSC_B_LOCK];
                ctl_q.cell_absent_run <= shift_q[`CSC_B_ABSENT];
            end else if (wr_stb_q && ptr_q == `CSC_OFS_CTRL) begin
                ctl_q.input_current_cap <= shift_q[`CSC_B_CAP_HI:`CSC_B_CAP_LO];
                ctl_q.stat_en <= shift_q[`CSC_B_STAT_EN];
                ctl_q.end_cutoff_on <= shift_q[`CSC_B_CUTOFF];
                ctl_q.charge_inhibit <= shift_q[`CSC_B_INHIBIT];
                ctl_q.hi_z_state <= shift_q[`CSC_B_HIZ];
            end
            if (expire) begin
                ctl_q.input_lockout <= 1'b0;
            end
        end
    end

    // Any write except a soft reset arms the watchdog, so a silent host cannot hold the lockout
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wdog_run_q <= 1'b0;
            wdog_cnt_q <= 32'h0;
            wdog_exp_q <= 1'b0;
        end else begin
            if (srst) begin
                wdog_run_q <= 1'b0;
                wdog_cnt_q <= 32'h0;
            end else if (expire) begin
                wdog_run_q <= 1'b0;
                wdog_cnt_q <= 32'h0;
            end else if (kick) begin
                wdog_run_q <= 1'b1;
                wdog_cnt_q <= 32'h0;
            end else begin
                wdog_run_q <= wdog_run_q | wr_stb_q;
                wdog_cnt_q <= wdog_run_q ? wdog_cnt_q + 32'h1 : 32'h0;
            end
            if (expire) begin
                wdog_exp_q <= 1'b1;
            end else if (kick || srst) begin
                wdog_exp_q <= 1'b0;
            end
        end
    end

    // Power path commands
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            drv_q <= '0;
        end else begin
            drv_q.converter_on <= !ctl_q.hi_z_state;
            drv_q.cell_fet_on <= ctl_q.hi_z_state || !ctl_q.charge_inhibit;
            drv_q.cell_gate_driver_on <= ctl_q.hi_z_state;
            drv_q.cell_gate_driver_hiz <= ctl_q.charge_inhibit && !ctl_q.hi_z_state;
            drv_q.load_rail_target_reg <= ctl_q.charge_inhibit && !ctl_q.hi_z_state;
            drv_q.supplement_ok <= !ctl_q.hi_z_state;
            drv_q.charge_allow <= !ctl_q.charge_inhibit && !ctl_q.hi_z_state &&
                                  !ctl_q.input_lockout;
            drv_q.cell_overvoltage_guard_off <= ctl_q.cell_absent_run;
        end
    end

    // Status pins; pulses show even with indication disabled
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prev_q <= 10'h000;
            prev_valid_q <= 1'b0;
            pulse_cnt_q <= 12'h000;
            stat_oe_q <= 1'b0;
            zero_q <= 1'b0;
        end else begin
            prev_q <= {r0[6:4], r0[2:0], r1[5:4], r1[2:1]};
            prev_valid_q <= 1'b1;
            if (chg) begin
                pulse_cnt_q <= PULSE_CYC;
            end else if (pulse_cnt_q != 12'h000) begin
                pulse_cnt_q <= pulse_cnt_q - 12'h001;
            end
            stat_oe_q <= chg || pulse_cnt_q > 12'h001 ||
                         (ctl_q.stat_en && mon.charge_state == `CSC_CHG_CHARGING);
        end
    end

    assign sda_out = zero_q;
    assign sda_oe = sda_oe_q;
    assign ctl = ctl_q;
    assign drv = drv_q;
    assign stat_out = zero_q;
    assign stat_oe = stat_oe_q;
    assign int_out = zero_q;
    assign int_oe = stat_oe_q;

    AST_KICK_RESTART: assert property (@(posedge core_clk) disable iff (rst)
        kick && !srst && !expire |=> wdog_cnt_q == 32'h0 && wdog_run_q)
        else $error("kick did not restart watchdog");
    AST_WDOG_ERR: assert property (@(posedge core_clk) disable iff (rst)
        expire |=> r0[2:0] == `CSC_ERR_WDOG)
        else $error("watchdog expiry not reported");
    AST_LOCK_DROP: assert property (@(posedge core_clk) disable iff (rst)
        expire |=> !ctl_q.input_lockout)
        else $error("lockout survived watchdog expiry");
    AST_SRST_DEF: assert property (@(posedge core_clk) disable iff (rst)
        srst |=> r2 == `CSC_CTRL_RESET && !wdog_run_q && r1[3] == 1'b0)
        else $error("soft reset left non-default state");
    AST_HIZ_PATH: assert property (@(posedge core_clk) disable iff (rst)
        ctl_q.hi_z_state |=> !drv_q.converter_on && drv_q.cell_fet_on && drv_q.cell_gate_driver_on)
        else $error("hi-z power path wrong");
    AST_PULSE_LEN: assert property (@(posedge core_clk) disable iff (rst)
        chg |=> pulse_cnt_q == PULSE_CYC && stat_oe_q)
        else $error("status pulse not started");
    AST_QUIET: assert property (@(posedge core_clk) disable iff (rst)
        !chg && pulse_cnt_q <= 12'h001 && !ctl_q.stat_en |=> !stat_oe_q)
        else $error("status pin driven with indication off");
    AST_NACK: assert property (@(posedge core_clk) disable iff (rst)
        scl_fall && !start && !stop && st_q == CSC_ADDR && cnt_q == 4'h8 &&
        shift_q[7:1] != `CSC_DEV_ADDR |=> st_q == CSC_IDLE && !sda_oe_q)
        else $error("foreign address acknowledged");
    AST_UNMAPPED: assert property (@(posedge core_clk) disable iff (rst)
        scl_fall && !start && !stop && st_q == CSC_ADDR_ACK && rw_q && ptr_q > `CSC_OFS_CTRL
        |=> tx_q == `CSC_UNMAPPED)
        else $error("unmapped read not FFh");

endmodule

// ==== rtl/csc_defines.svh ====
`ifndef CSC_DEFINES_SVH
`define CSC_DEFINES_SVH

`define CSC_DEV_ADDR 7'h6b
`define CSC_OFS_STATUS 8'h00
`define CSC_OFS_SUPPLY 8'h01
`define CSC_OFS_CTRL 8'h02
`define CSC_UNMAPPED 8'hff

`define CSC_B_KICK 7
`define CSC_B_LOCK 3
`define CSC_B_ABSENT 0
`define CSC_B_SRST 7
`define CSC_B_CAP_HI 6
`define CSC_B_CAP_LO 4
`define CSC_B_STAT_EN 3
`define CSC_B_CUTOFF 2
`define CSC_B_INHIBIT 1
`define CSC_B_HIZ 0

`define CSC_CTRL_RESET 8'h8c
`define CSC_CAP_RESET 3'h0
`define CSC_CHG_CHARGING 3'h4
`define CSC_ERR_WDOG 3'h3

`define CSC_PULSE_NS 128000
`define CSC_CLK_NS 50
`define CSC_WDOG_CYCLES 32'h000f4240

`endif

// ==== rtl/csc_pkg.sv ====
package csc_pkg;

    typedef enum logic [8:0] {
        CSC_IDLE = 9'h001,
        CSC_ADDR = 9'h002,
        CSC_ADDR_ACK = 9'h004,
        CSC_REG = 9'h008,
        CSC_REG_ACK = 9'h010,
        CSC_WDATA = 9'h020,
        CSC_WDATA_ACK = 9'h040,
        CSC_RDATA = 9'h080,
        CSC_RDATA_ACK = 9'h100
    } csc_state_type;

    // Status reported by the analog charger core
    typedef struct packed {
        logic [2:0] charge_state;
        logic [2:0] fault_code;
        logic [1:0] input_supply_state;
        logic [1:0] cell_state;
    } csc_mon_type;

    // Software-visible control fields
    typedef struct packed {
        logic input_lockout;
        logic cell_absent_run;
        logic [2:0] input_current_cap;
        logic stat_en;
        logic end_cutoff_on;
        logic charge_inhibit;
        logic hi_z_state;
    } csc_ctl_type;

    // Power path commands derived from the control fields
    typedef struct packed {
        logic converter_on;
        logic cell_fet_on;
        logic cell_gate_driver_on;
        logic cell_gate_driver_hiz;
        logic load_rail_target_reg;
        logic supplement_ok;
        logic charge_allow;
        logic cell_overvoltage_guard_off;
    } csc_drv_type;

endpackage

// ==== verif/csc_host_model.sv ====
`timescale 1ns/1ps
`include "csc_defines.svh"
module csc_host_model #(
    parameter int HALF = 8,
    parameter logic [6:0] ADDR = `CSC_DEV_ADDR
) (
    input wire logic core_clk,
    input wire logic sda,
    output logic scl_o,
    output logic sda_low_o
);
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // Spare cycles after scl falls keep data changes clear of the slave sample
    task automatic bit_x(input logic b, output logic s);
        tick(2);
        sda_low_o = ~b;
        tick(HALF);
        scl_o = 1'b1;
        tick(HALF);
        s = sda;
        scl_o = 1'b0;
    endtask

    task automatic start_c();
        tick(2);
        sda_low_o = 1'b0;
        tick(HALF);
        scl_o = 1'b1;
        tick(HALF);
        sda_low_o = 1'b1;
        tick(HALF);
        scl_o = 1'b0;
    endtask

    task automatic stop_c();
        tick(2);
        sda_low_o = 1'b1;
        tick(HALF);
        scl_o = 1'b1;
        tick(HALF);
        sda_low_o = 1'b0;
        tick(HALF);
    endtask

    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(b[i], s);
        end
        bit_x(1'b1, s);
        ack = ~s;
    endtask

    // Last byte is refused so the slave lets go of sda before stop
    task automatic get_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, s);
            b[i] = s;
        end
        bit_x(last, s);
    endtask

    task automatic write_burst(input logic [7:0] r, input logic [2:0][7:0] d, input int n,
                               output logic ok);
        logic a;
        start_c();
        put_byte({ADDR, 1'b0}, a);
        ok = a;
        put_byte(r, a);
        ok = ok & a;
        for (int i = n - 1; i >= 0; i--) begin
            put_byte(d[i], a);
            ok = ok & a;
        end
        stop_c();
    endtask

    task automatic read_burst(input logic [7:0] r, input int n, output logic [2:0][7:0] q,
                              output logic ok);
        logic a;
        q = '0;
        start_c();
        put_byte({ADDR, 1'b0}, a);
        ok = a;
        put_byte(r, a);
        ok = ok & a;
        start_c();
        put_byte({ADDR, 1'b1}, a);
        ok = ok & a;
        for (int i = n - 1; i >= 0; i--) begin
            get_byte(i == 0, q[i]);
        end
        stop_c();
    endtask
endmodule

// ==== verif/tb.sv ====
`timescale 1ns/1ps
module tb;
    import csc_pkg::*;
    localparam int WDOG = 4000;
    typedef struct packed {
        csc_mon_type mon;
        logic [7:0] wr;
        logic [7:0] r0;
        logic [7:0] r1;
        logic [7:0] r2;
    } csc_row_type;
    localparam csc_row_type ROWS [6] = '{
        {3'h0, 3'h0, 2'h0, 2'h0, 8'h0c, 8'h00, 8'h00, 8'h8c},
        {3'h2, 3'h1, 2'h1, 2'h1, 8'h1c, 8'h21, 8'h12, 8'h9c},
        {3'h4, 3'h2, 2'h2, 2'h2, 8'h2c, 8'h42, 8'h24, 8'hac},
        {3'h5, 3'h4, 2'h3, 2'h0, 8'h3c, 8'h54, 8'h30, 8'hbc},
        {3'h7, 3'h6, 2'h0, 2'h1, 8'h4c, 8'h76, 8'h02, 8'hcc},
        {3'h7, 3'h7, 2'h0, 2'h0, 8'h5c, 8'h77, 8'h00, 8'hdc}
    };
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic scl;
    logic host_low;
    logic sda_wire;
    logic sda_out;
    logic sda_oe;
    logic stat_out;
    logic stat_oe;
    logic int_out;
    logic int_oe;
    csc_mon_type mon = '0;
    csc_ctl_type ctl;
    csc_drv_type drv;
    int miscompares = 0;
    int check_count = 0;
    logic [2:0][7:0] rd;
    logic ok;
    int n;

    always #25 core_clk = ~core_clk;
    // Pull-up on sda: low when either side pulls
    assign sda_wire = ~(host_low | (sda_oe & ~sda_out));

    csc_regs #(.WDOG_CYCLES(32'd4000)) i_dut (.core_clk(core_clk), .rst(rst), .scl_in(scl),
        .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe), .mon(mon), .ctl(ctl),
        .drv(drv), .stat_out(stat_out), .stat_oe(stat_oe), .int_out(int_out), .int_oe(int_oe));
    csc_host_model #(.HALF(8)) i_host (.core_clk(core_clk), .sda(sda_wire), .scl_o(scl),
        .sda_low_o(host_low));

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic pulse(input logic [2:0] cs, output int len);
        mon.charge_state = cs;
        len = 0;
        for (int k = 0; k < 4 && int_oe !== 1'b1; k++) begin
            @(posedge core_clk);
            #1;
        end
        while (int_oe === 1'b1 && len < 3000) begin
            len++;
            @(posedge core_clk);
            #1;
        end
    endtask

    initial begin
        repeat (10) @(posedge core_clk);
        #1;
        chk("ctl in reset", 16'h00c, 16'(ctl));
        rst = 1'b0;
        foreach (ROWS[i]) begin
            mon = ROWS[i].mon;
            i_host.write_burst(8'h00, {8'h80, 8'h00, ROWS[i].wr}, 3, ok);
            chk("write ack", 16'h1, 16'(ok));
            i_host.read_burst(8'h00, 3, rd, ok);
            chk("status reg", 16'(ROWS[i].r0), 16'(rd[2]));
            chk("supply reg", 16'(ROWS[i].r1), 16'(rd[1]));
            chk("control reg", 16'(ROWS[i].r2), 16'(rd[0]));
            chk("cap field", 16'(ROWS[i].wr[6:4]), 16'(ctl.input_current_cap));
        end
        i_host.write_burst(8'h00, {8'h0, 8'h80, 8'h08}, 2, ok);
        chk("lockout set", 16'h1, 16'(ctl.input_lockout));
        chk("lockout blocks charge", 16'h0, 16'(drv.charge_allow));
        n = 0;
        while (ctl.input_lockout === 1'b1 && n < 2 * WDOG) begin
            @(posedge core_clk);
            n++;
        end
        #1;
        chk("lockout expiry time", 16'h1, 16'(n > WDOG - 300 && n <= WDOG));
        i_host.read_burst(8'h00, 1, rd, ok);
        chk("expired code", 16'h73, 16'(rd[0]));
        i_host.write_burst(8'h00, {16'h0, 8'h80}, 1, ok);
        i_host.read_burst(8'h00, 1, rd, ok);
        chk("code after kick", 16'h77, 16'(rd[0]));
        i_host.write_burst(8'h02, {16'h0, 8'h53}, 1, ok);
        i_host.write_burst(8'h01, {16'h0, 8'h01}, 1, ok);
        chk("ctl fields", 16'h0d3, 16'(ctl));
        chk("hiz path", 16'h3, 16'({drv.converter_on, drv.cell_fet_on,
            drv.cell_gate_driver_on}));
        chk("guard off", 16'h1, 16'(drv.cell_overvoltage_guard_off));
        i_host.write_burst(8'h02, {16'h0, 8'h52}, 1, ok);
        chk("inhibit path", 16'h7, 16'({drv.charge_allow, drv.cell_gate_driver_hiz,
            drv.load_rail_target_reg, drv.supplement_ok}));
        i_host.write_burst(8'h02, {16'h0, 8'h80}, 1, ok);
        chk("ctl after soft reset", 16'h00c, 16'(ctl));
        i_host.read_burst(8'h01, 2, rd, ok);
        chk("supply after soft reset", 16'h00, 16'(rd[1]));
        chk("control after soft reset", 16'h8c, 16'(rd[0]));
        i_host.read_burst(8'h10, 1, rd, ok);
        chk("unmapped read", 16'hff, 16'(rd[0]));
        i_host.start_c();
        i_host.put_byte(8'hd4, ok);
        i_host.stop_c();
        chk("foreign address ack", 16'h0, 16'(ok));
        pulse(3'h2, n);
        chk("pulse length", 16'h0a00, 16'(n));
        chk("pins released", 16'h0, 16'({stat_oe, stat_out, int_out}));
        pulse(3'h4, n);
        chk("charging shown", 16'h1, 16'(stat_oe));
        i_host.write_burst(8'h02, {16'h0, 8'h04}, 1, ok);
        pulse(3'h5, n);
        chk("pulse with indication off", 16'h0a00, 16'(n));
        chk("stat after pulse", 16'h0, 16'(stat_oe));
        // Mid-run reset must restore defaults and leave the bus usable
        rst = 1'b1;
        @(posedge core_clk);
        #1;
        chk("ctl in mid-run reset", 16'h00c, 16'(ctl));
        chk("drv in reset", 16'h0, 16'(drv));
        chk("pins in reset", 16'h0, 16'({stat_oe, sda_oe}));
        rst = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        chk("drv after reset", 16'h00c6, 16'(drv));
        i_host.read_burst(8'h02, 1, rd, ok);
        chk("control after reset", 16'h8c, 16'(rd[0]));
        test_done();
    end

    initial begin
        repeat (60000) @(posedge core_clk);
        miscompares++;
        test_done();
    end
endmodule
